// file: rtl/pcs_pkg.sv
// Notes on behaviour
// RULE_01: Bits 5:3 of the PLL configuration register pick the charge-pump current, 50 to 1500 microamps.
// RULE_02: While coast is active the PLL holds frequency and phase, and it tracks horizontal sync again after.
// RULE_03: Bit 5 of register 0Fh picks the external coast pin or the internal vertical sync as coast source.
// RULE_04: The internal coast source is vertical sync from the sync pin or from the sync separator.
// RULE_05: With vertical sync as source the window is widened by pre-coast and post-coast counts in 12h and 13h.
// RULE_06: An 11-bit counter measures horizontal sync pulses per frame, up to 2048 lines.
// RULE_07: From the measured frame the next vertical sync is predicted and coast starts up to 255 lines early.
// RULE_08: After vertical sync ends coast is held for the post-coast count of lines, up to 255.
// RULE_09: Coast polarity comes from duty cycle, mostly low gives 1 and mostly high gives 0, in bit 0 of 14h.
// RULE_10: A high sample-clock invert input inverts the converter sampling clock, a 180 degree shift.
// RULE_11: For alternate pixel sampling the controller halves the divider and toggles the invert input per frame.
// RULE_12: The controller changes the invert input only in vertical blanking.
// RULE_13: The top two bits of the PLL configuration register pick the VCO range.
// RULE_14: Internal coast is the OR of pre-coast window, corrected vertical sync and post-coast window per line.
package pcs_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_PLL_CFG    = 6'h03;
  localparam logic [5:0] IDX_COAST_CFG  = 6'h0f;
  localparam logic [5:0] IDX_PRE_COAST  = 6'h12;
  localparam logic [5:0] IDX_POST_COAST = 6'h13;
  localparam logic [5:0] IDX_STATUS     = 6'h14;
  localparam logic [5:0] IDX_FRAME_LEN  = 6'h16;

  // Field positions
  localparam int VCO_MSB       = 7;
  localparam int VCO_LSB       = 6;
  localparam int PUMP_MSB      = 5;
  localparam int PUMP_LSB      = 3;
  localparam int COAST_SRC_BIT = 5;
  localparam int COAST_POL_BIT = 0;

  // Reset values
  localparam logic [7:0] RST_PLL_CFG    = 8'h48;
  localparam logic       RST_COAST_SRC  = 1'h0;
  localparam logic [7:0] RST_PRE_COAST  = 8'h00;
  localparam logic [7:0] RST_POST_COAST = 8'h00;
  localparam logic       RST_POLARITY   = 1'h1;

  // Charge-pump current in microamps, indexed by the 3-bit code
  localparam logic [7:0][10:0] PUMP_UA = {11'h5dc, 11'h2ee, 11'h1f4, 11'h15e,
                                          11'h0fa, 11'h096, 11'h064, 11'h032};

  // Pin positions in the synchroniser vector
  localparam int PIN_HSYNC   = 0;
  localparam int PIN_VSYNC   = 1;
  localparam int PIN_VSEP    = 2;
  localparam int PIN_VSEL    = 3;
  localparam int PIN_COAST   = 4;
  localparam int PIN_INVERT  = 5;
  localparam int PIN_COUNT   = 6;

  localparam int LINE_W = 11;

endpackage : pcs_pkg

// file: rtl/pcs_pol_if.sv
`timescale 1ns/1ps
interface pcs_pol_if;
  logic sample;
  logic polarity;
  modport det  (input sample, output polarity);
  modport user (output sample, input polarity);
endinterface : pcs_pol_if

// file: rtl/pcs_pol_det.sv
`timescale 1ns/1ps
// Duty-cycle polarity detector: over each window counts high samples
module pcs_pol_det #(
  parameter int WIN_LOG2 = 16
) (
  input wire logic   hclk,
  input wire logic   hresetn,
  pcs_pol_if.det     pol
);

  typedef struct packed {
    logic [WIN_LOG2-1:0] total;
    logic [WIN_LOG2:0]   high;
    logic                polarity;
  } pcs_det_s;

  pcs_det_s st_r;
  pcs_det_s st_nxt;

  localparam logic [WIN_LOG2:0] HALF = (WIN_LOG2+1)'(1) << (WIN_LOG2-1);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.high = st_r.high + (WIN_LOG2+1)'(pol.sample);
    st_nxt.total = st_r.total + WIN_LOG2'(1);
    if (&st_r.total)
    begin
      // Mostly low reads as positive
      st_nxt.polarity = (st_nxt.high < HALF); // RULE_09
      st_nxt.high = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '{total: '0, high: '0, polarity: pcs_pkg::RST_POLARITY};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pol.polarity = st_r.polarity;

endmodule : pcs_pol_det

// file: rtl/pcs_coast_ctrl.sv
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// PLL coast and sample-phase control with AHB-Lite register slave
module pcs_coast_ctrl #(
  parameter int POL_WIN_LOG2 = 16
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        hsync_ref,
  input  wire logic        vsync_pin,
  input  wire logic        vsync_sep,
  input  wire logic        vsync_sep_select,
  input  wire logic        coast_pin,
  input  wire logic        sample_clock_invert,
  output logic             pll_coast,
  output logic             pll_phase_track,
  output logic             adc_clock_invert,
  output logic [1:0]       vco_range,
  output logic [2:0]       pump_current,
  output logic [10:0]      pump_current_ua
);

  localparam int NP = pcs_pkg::PIN_COUNT;
  localparam int LW = pcs_pkg::LINE_W;

  typedef struct packed {
    logic [2:0][NP-1:0] sy;
    logic [NP-1:0]      pin;
    logic               hs_d;
    logic               vact_d;
    logic               dp;
    logic               dp_wr;
    logic [5:0]         dp_idx;
    logic               rdy;
    logic               resp;
    logic [31:0]        rdata;
    logic [7:0]         pll_cfg;
    logic               coast_ext;
    logic [7:0]         pre;
    logic [7:0]         post;
    logic [LW-1:0]      line_idx;
    logic [LW-1:0]      frame_last;
    logic               frame_ok;
    logic [7:0]         post_cnt;
    logic               coast_int;
    logic               coast;
    logic               track;
    logic               adc_inv;
    logic [1:0]         vco;
    logic [2:0]         pump;
    logic [10:0]        pump_ua;
  } pcs_top_s;

  pcs_top_s st_r;
  pcs_top_s st_nxt;

  pcs_pol_if coast_pol ();
  pcs_pol_if vsync_pol ();

  logic [NP-1:0] pins_raw;
  logic          vs_raw;
  logic          vact;
  logic          ext_act;
  logic          hs_edge;
  logic          pre_win;
  logic [LW:0]   reach;
  logic [31:0]   rd_mux;
  logic          vs_start;
  logic          vs_end;

  always_comb
  begin
    pins_raw = '0;
    pins_raw[pcs_pkg::PIN_HSYNC] = hsync_ref;
    pins_raw[pcs_pkg::PIN_VSYNC] = vsync_pin;
    pins_raw[pcs_pkg::PIN_VSEP]  = vsync_sep;
    pins_raw[pcs_pkg::PIN_VSEL]  = vsync_sep_select;
    pins_raw[pcs_pkg::PIN_COAST] = coast_pin;
    pins_raw[pcs_pkg::PIN_INVERT] = sample_clock_invert;
  end

  // Vertical sync from pin or from the separator, then polarity corrected
  assign vs_raw = st_r.pin[pcs_pkg::PIN_VSEL] ? st_r.pin[pcs_pkg::PIN_VSEP]
                                              : st_r.pin[pcs_pkg::PIN_VSYNC]; // RULE_04
  assign vact    = ~(vs_raw ^ vsync_pol.polarity);
  assign ext_act = ~(st_r.pin[pcs_pkg::PIN_COAST] ^ coast_pol.polarity);
  assign hs_edge = st_r.pin[pcs_pkg::PIN_HSYNC] & ~st_r.hs_d;

  assign coast_pol.sample = st_r.pin[pcs_pkg::PIN_COAST];
  assign vsync_pol.sample = vs_raw;

  pcs_pol_det #(
    .WIN_LOG2 (POL_WIN_LOG2)
  ) u_coast_pol (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pol     (coast_pol.det)
  );

  pcs_pol_det #(
    .WIN_LOG2 (POL_WIN_LOG2)
  ) u_vsync_pol (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pol     (vsync_pol.det)
  );

  // Line index plus pre-coast reaching the last line predicts next vsync;
  // the lines with index frame_last-pre .. frame_last-1 give exactly pre lines
  assign reach   = {1'b0, st_r.line_idx} + (LW+1)'(st_r.pre);
  assign pre_win = st_r.frame_ok && (st_r.pre != 8'h00) && !vact
                   && (reach >= {1'b0, st_r.frame_last}); // RULE_07
  assign vs_start = vact & ~st_r.vact_d;
  assign vs_end   = ~vact & st_r.vact_d;

  always_comb
  begin
    rd_mux = '0;
    unique case (st_r.dp_idx)
      pcs_pkg::IDX_PLL_CFG:    rd_mux[7:0] = {st_r.pll_cfg[7:3], 3'h0};
      pcs_pkg::IDX_COAST_CFG:  rd_mux[pcs_pkg::COAST_SRC_BIT] = st_r.coast_ext;
      pcs_pkg::IDX_PRE_COAST:  rd_mux[7:0] = st_r.pre;
      pcs_pkg::IDX_POST_COAST: rd_mux[7:0] = st_r.post;
      pcs_pkg::IDX_STATUS:     rd_mux[pcs_pkg::COAST_POL_BIT] = coast_pol.polarity; // RULE_09
      pcs_pkg::IDX_FRAME_LEN:  rd_mux[LW-1:0] = st_r.frame_last;
      default:                 rd_mux = '0;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;

    // Three-stage pin synchronisers; a change counts once stages two and three agree
    st_nxt.sy[0] = pins_raw;
    st_nxt.sy[1] = st_r.sy[0];
    st_nxt.sy[2] = st_r.sy[1];
    for (int i = 0; i < NP; i++)
    begin
      if (st_r.sy[1][i] == st_r.sy[2][i])
      begin
        st_nxt.pin[i] = st_r.sy[2][i];
      end
    end

    // Bus slave: one wait state per transfer so read data comes from a flop
    st_nxt.resp = 1'b0;
    if (st_r.dp && !st_r.rdy)
    begin
      st_nxt.rdy = 1'b1;
      st_nxt.dp  = 1'b0;
      if (st_r.dp_wr)
      begin
        unique case (st_r.dp_idx)
          pcs_pkg::IDX_PLL_CFG:    st_nxt.pll_cfg = {hwdata[7:3], 3'h0};
          pcs_pkg::IDX_COAST_CFG:  st_nxt.coast_ext = hwdata[pcs_pkg::COAST_SRC_BIT]; // RULE_03
          pcs_pkg::IDX_PRE_COAST:  st_nxt.pre = hwdata[7:0]; // RULE_05
          pcs_pkg::IDX_POST_COAST: st_nxt.post = hwdata[7:0]; // RULE_05
          default:                 st_nxt.rdy = 1'b1;
        endcase
      end
      else
      begin
        st_nxt.rdata = rd_mux;
      end
    end
    else if (hsel && htrans[1] && hready)
    begin
      st_nxt.dp     = 1'b1;
      st_nxt.dp_wr  = hwrite;
      st_nxt.dp_idx = haddr[7:2];
      st_nxt.rdy    = 1'b0;
    end

    // Line counting and coast windows advance on each horizontal sync edge
    st_nxt.hs_d = st_r.pin[pcs_pkg::PIN_HSYNC];
    if (hs_edge)
    begin
      st_nxt.vact_d = vact;
      if (vs_start)
      begin
        st_nxt.frame_last = st_r.line_idx; // RULE_06
        st_nxt.frame_ok   = 1'b1;
        st_nxt.line_idx   = '0;
      end
      else if (!(&st_r.line_idx))
      begin
        st_nxt.line_idx = st_r.line_idx + LW'(1); // RULE_06
      end
      if (vs_end)
      begin
        st_nxt.post_cnt = st_r.post; // RULE_08
      end
      else if (st_r.post_cnt != 8'h00)
      begin
        st_nxt.post_cnt = st_r.post_cnt - 8'h01; // RULE_08
      end
      st_nxt.coast_int = pre_win | vact | (st_nxt.post_cnt != 8'h00); // RULE_14
    end

    // Coast freezes the PLL; tracking resumes when it drops
    st_nxt.coast = st_r.coast_ext ? ext_act : st_r.coast_int; // RULE_03
    st_nxt.track = ~st_nxt.coast; // RULE_02
    st_nxt.adc_inv = st_r.pin[pcs_pkg::PIN_INVERT]; // RULE_10
    st_nxt.vco = st_r.pll_cfg[pcs_pkg::VCO_MSB:pcs_pkg::VCO_LSB]; // RULE_13
    st_nxt.pump = st_r.pll_cfg[pcs_pkg::PUMP_MSB:pcs_pkg::PUMP_LSB]; // RULE_01
    st_nxt.pump_ua = pcs_pkg::PUMP_UA[st_nxt.pump]; // RULE_01
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r            <= '0;
      st_r.rdy        <= 1'b1;
      st_r.pll_cfg    <= pcs_pkg::RST_PLL_CFG;
      st_r.coast_ext  <= pcs_pkg::RST_COAST_SRC;
      st_r.pre        <= pcs_pkg::RST_PRE_COAST;
      st_r.post       <= pcs_pkg::RST_POST_COAST;
      st_r.track      <= 1'b1;
      st_r.vco        <= pcs_pkg::RST_PLL_CFG[pcs_pkg::VCO_MSB:pcs_pkg::VCO_LSB];
      st_r.pump       <= pcs_pkg::RST_PLL_CFG[pcs_pkg::PUMP_MSB:pcs_pkg::PUMP_LSB];
      st_r.pump_ua    <= pcs_pkg::PUMP_UA[pcs_pkg::RST_PLL_CFG[pcs_pkg::PUMP_MSB:pcs_pkg::PUMP_LSB]];
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout       = st_r.rdy;
  assign hresp           = st_r.resp;
  assign hrdata          = st_r.rdata;
  assign pll_coast       = st_r.coast;
  assign pll_phase_track = st_r.track;
  assign adc_clock_invert = st_r.adc_inv;
  assign vco_range       = st_r.vco;
  assign pump_current    = st_r.pump;
  assign pump_current_ua = st_r.pump_ua;

endmodule : pcs_coast_ctrl

// file: verification/pcs_coast_ctrl_checker.sv
`timescale 1ns/1ps
module pcs_coast_ctrl_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        sample_clock_invert,
  input wire logic        pll_coast,
  input wire logic        pll_phase_track,
  input wire logic        adc_clock_invert,
  input wire logic [1:0]  vco_range,
  input wire logic [2:0]  pump_current,
  input wire logic [10:0] pump_current_ua
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic       tk;
  logic [5:0] ix;
  assign tk = hsel && htrans[1] && hready;
  assign ix = haddr[7:2];
  chk_track_inverse: assert property (pll_phase_track == !pll_coast)
    else $error("phase track not inverse of coast");
  chk_wait_one: assert property (tk |=> !hreadyout ##1 hreadyout)
    else $error("wait state not one cycle");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_pump_write: assert property (tk && hwrite && ix == 6'h03 |=> ##3 pump_current == $past(hwdata[5:3], 3))
    else $error("pump code not taken from write");
  chk_vco_write: assert property (tk && hwrite && ix == 6'h03 |=> ##3 vco_range == $past(hwdata[7:6], 3))
    else $error("vco range not taken from write");
  chk_pump_value: assert property (pump_current_ua == pcs_pkg::PUMP_UA[pump_current])
    else $error("pump current value wrong");
  chk_cfg_read: assert property (tk && !hwrite && ix == 6'h03 |=> ##2 hrdata[7:0] == {vco_range, pump_current, 3'h0})
    else $error("config readback wrong");
  chk_frame_width: assert property (tk && !hwrite && ix == 6'h16 |=> ##1 hrdata[31:11] == 21'h0)
    else $error("frame length wider than counter");
  chk_invert_follow: assert property ((sample_clock_invert == $past(sample_clock_invert)) [*8] |-> adc_clock_invert == sample_clock_invert)
    else $error("sample clock invert not followed");
  cover property (tk && hwrite);
  cover property ($rose(pll_coast));
  cover property ($rose(adc_clock_invert));
endmodule : pcs_coast_ctrl_checker
bind pcs_coast_ctrl pcs_coast_ctrl_checker chk (.*);

// file: verification/pcs_video_model.sv
`timescale 1ns/1ps
// Video source and frame controller; vsync covers the first VS_LINES lines
module pcs_video_model #(
  parameter int LINE_CYC = 32,
  parameter int LINES    = 12,
  parameter int VS_LINES = 2
) (
  input  wire logic hclk,
  input  wire logic run,
  output logic      hsync,
  output logic      vsync,
  output logic      invert
);
  int cyc;
  int line;
  initial
  begin
    cyc = 0;
    line = 0;
    hsync = 1'b0;
    vsync = 1'b0;
    invert = 1'b0;
  end
  always @(posedge hclk)
  begin
    if (run)
    begin
      cyc <= (cyc == LINE_CYC - 1) ? 0 : cyc + 1;
      if (cyc == LINE_CYC - 1)
        line <= (line == LINES - 1) ? 0 : line + 1;
      hsync <= cyc < 3;
      // Vsync moves mid-line so it is never sampled on the same edge as hsync
      if (cyc == 6)
        vsync <= line < VS_LINES;
      // Flip once a frame inside vsync, where corrupted samples do no harm
      if (cyc == 8 && line == 1)
        invert <= !invert;
    end
  end
endmodule : pcs_video_model

// file: verification/pll_coast_and_sample_phase_bench.sv
`timescale 1ns/1ps
module pll_coast_and_sample_phase_bench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, vco_range;
  logic [2:0]  hsize, pump_current;
  logic        hsync_ref, vs, sep_sel, coast_pin, sci, run;
  logic        pll_coast, pll_phase_track, adc_clock_invert;
  logic [10:0] pump_current_ua;
  int          error_cnt, tests_run, n;
  localparam logic [10:0] UA [8] = '{11'h032, 11'h064, 11'h096, 11'h0fa, 11'h15e, 11'h1f4, 11'h2ee, 11'h5dc};
  localparam logic [7:0]  PRE [3] = '{8'h02, 8'h00, 8'h01};
  localparam logic [7:0]  POST [3] = '{8'h03, 8'h00, 8'h04};
  assign hready = hreadyout;
  pcs_video_model src (.hclk(hclk), .run(run), .hsync(hsync_ref), .vsync(vs), .invert(sci));
  pcs_coast_ctrl #(.POL_WIN_LOG2(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .hsync_ref(hsync_ref), .vsync_pin(sep_sel ? 1'b0 : vs),
    .vsync_sep(sep_sel ? vs : 1'b0), .vsync_sep_select(sep_sel), .coast_pin(coast_pin),
    .sample_clock_invert(sci), .pll_coast(pll_coast), .pll_phase_track(pll_phase_track),
    .adc_clock_invert(adc_clock_invert), .vco_range(vco_range), .pump_current(pump_current),
    .pump_current_ua(pump_current_ua));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic results();
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : check
  task automatic bound(input logic ok);
    if (!ok)
    begin
      check(1'b0, "wait timed out");
      results();
    end
  endtask : bound
  task automatic hwait();
    int k;
    k = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && k < 20)
    begin
      @(posedge hclk);
      k++;
    end
    bound(k < 20);
  endtask : hwait
  task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, ix, 2'h0};
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask : xfer
  // Samples each line well after the sync latency, so edge timing does not matter
  task automatic frame(input int exp);
    int k;
    n = 0;
    repeat (12)
    begin
      k = 0;
      while (hsync_ref !== 1'b1 && k < 40)
      begin
        @(posedge hclk);
        k++;
      end
      bound(k < 40);
      repeat (16) @(posedge hclk);
      n += pll_coast;
      check(pll_phase_track === !pll_coast, "phase track");
      check(adc_clock_invert === sci, "sample clock invert");
    end
    check(n == exp, "coast line count");
  endtask : frame
  initial
  begin
    error_cnt = 0;
    tests_run = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sep_sel = 1'b0;
    coast_pin = 1'b0;
    run = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    check(pll_coast === 1'b0 && vco_range === 2'h1 && pump_current_ua === 11'h064, "reset outputs");
    xfer(1'b0, 6'h03, 32'h0);
    check(q === 32'h48, "config reset");
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 6'h03, {24'h0, i[1:0], i[2:0], 3'h7});
      xfer(1'b0, 6'h03, 32'h0);
      check(q === {24'h0, i[1:0], i[2:0], 3'h0}, "config readback");
      check(pump_current === i[2:0] && pump_current_ua === UA[i], "pump current");
    end
    xfer(1'b1, 6'h3f, 32'hffffffff);
    xfer(1'b0, 6'h3f, 32'h0);
    check(q === 32'h0, "unmapped read");
    xfer(1'b1, 6'h0f, 32'h20);
    coast_pin <= 1'b1;
    repeat (10) @(posedge hclk);
    check(pll_coast === 1'b1 && pll_phase_track === 1'b0, "external coast");
    repeat (2200) @(posedge hclk);
    xfer(1'b0, 6'h14, 32'h0);
    check(q[0] === 1'b0 && pll_coast === 1'b0, "negative coast");
    coast_pin <= 1'b0;
    repeat (2200) @(posedge hclk);
    xfer(1'b0, 6'h14, 32'h0);
    check(q[0] === 1'b1 && pll_coast === 1'b0, "positive coast");
    run <= 1'b1;
    for (int j = 0; j < 3; j++)
    begin
      xfer(1'b1, 6'h0f, 32'h0);
      xfer(1'b1, 6'h12, {24'h0, PRE[j]});
      xfer(1'b1, 6'h13, {24'h0, POST[j]});
      sep_sel <= j[1];
      repeat (1200) @(posedge hclk);
      frame(PRE[j] + POST[j] + 2);
      xfer(1'b0, 6'h16, 32'h0);
      check(q === 32'h0000000b, "frame length");
    end
    results();
  end
endmodule : pll_coast_and_sample_phase_bench
